// *** include/lbi_defines.vh ***
`ifndef LBI_DEFINES_VH
`define LBI_DEFINES_VH

// Register indices; byte address is four times the index
`define LBI_IDX_PIN_SEL 6'h2B
`define LBI_IDX_BLINK 6'h2C
`define LBI_IDX_POLARITY 6'h2D
`define LBI_IDX_IRQ_STAT 6'h30
`define LBI_IDX_IRQ_MASK 6'h31

// intrusion_led_mode_pin_select fields
`define LBI_B_THERM_SEL 6
`define LBI_B_INTR_LEVEL 5
`define LBI_B_INTR_STAT 4
`define LBI_B_MODE_HI 3
`define LBI_B_MODE_LO 2
`define LBI_B_INFRARED_RECEIVE_FIRST_SEL 1
`define LBI_B_IRRX2_SEL 0

// led_blink_config fields
`define LBI_C_DUAL 7
`define LBI_C_PWR_SLEEP 6
`define LBI_C_LED2_HI 5
`define LBI_C_LED2_LO 3
`define LBI_C_LED1_HI 2
`define LBI_C_LED1_LO 0

// Polarity register field
`define LBI_D_POLARITY 7

// Interrupt status / mask bits
`define LBI_IRQ_INTRUSION 0
`define LBI_IRQ_RATE_LOAD 1
`define LBI_IRQ_BITS 2

// LED modes
`define LBI_MODE_SW 2'h0
`define LBI_MODE_HW1 2'h1
`define LBI_MODE_HW2 2'h2

// Blink codes
`define LBI_RATE_OFF 3'h0
`define LBI_RATE_1HZ 3'h3
`define LBI_RATE_ON 3'h7

// Reset values
`define LBI_RST_BLINK 8'h00
`define LBI_RST_DUAL 1'b0
`define LBI_RST_LED2 3'h7
`define LBI_RST_LED1 3'h0

// Time base: one tick of 1/48 s, 384 ticks make the 8 s period
`define LBI_CLK_MHZ 125
`define LBI_TICK_US 20833
`define LBI_TICK_CYCLES (`LBI_TICK_US * `LBI_CLK_MHZ)
`define LBI_PERIOD_TICKS 9'd384

`endif

// *** src/lbi_config.v ***
// Notes on behaviour
// - All configuration state lives in the always-powered domain; loss of main supply changes only the LED2 rate and rate-load irq bit, in hardware mode 1.
// - Bit 6 of the pin select register picks diode inputs when 0 (default) and thermistor inputs when 1.
// - Bit 5 reads the live chassis intrusion input level with no latching.
// - The intrusion status flag is cleared by writing 0 to bit 4, and writing 1 leaves it alone.
// - The intrusion status flag reads 1 after power-up reset, 0 meaning no intrusion.
// - LED mode bits 3-2 select software (00, default), hardware 1 (01), hardware 2 (10); 11 is reserved.
// - LED mode defaults to hardware 1 when the supply control straps disable supply control.
// - Bit 1 routes its pin to a general input when 0 (default) and the first infrared receive input when 1.
// - Bit 0 routes its pin to a general input when 0 (default) and the second infrared receive input when 1.
// - Blink config bit 7 selects one dual-coloured LED when 0 (default) and two LEDs when 1.
// - Bit 6 acts only in hardware mode 2, where 0 turns the power LED off in deep sleep and 1 leaves it.
// - LED1 rate resets to the off code.
// - LED2 rate in bits 5-3 uses the same codes and resets to the on code.
// - In hardware mode 1 the device loads 1 Hz 50% at standby power-up or when main power drops.
// - A polarity control chooses active-high (default) or active-low lit LED outputs.
`timescale 1ns/1ps
`include "lbi_defines.vh"

module lbi_config #(
  parameter TICK_CYCLES = `LBI_TICK_CYCLES,
  parameter [1:0] STRAP_SUPPLY_OFF = 2'h3
) (
  input wire core_clk, // 125 MHz clock
  input wire sys_rst, // Standby power-up reset, sync, high
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write
  input wire [7:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire chassis_intrusion_input, // Chassis intrusion pin level
  input wire [1:0] supply_control_straps, // Strap pins, sampled in reset
  input wire main_pwr_good, // Main supply present
  input wire deep_sleep, // Deep sleep or soft-off state
  output wire therm_sel, // 1: thermistor inputs, 0: diode inputs
  output wire infrared_receive_first_sel, // 1: first infrared receive input
  output wire irrx2_sel, // 1: second infrared receive input
  output reg led1_out, // Power LED drive
  output reg led2_out, // Second LED drive
  output wire irq // Level interrupt
);

  localparam TICK_W = 32;

  reg therm_sel_ff;
  reg intr_stat_ff;
  reg [1:0] mode_ff;
  reg infrared_receive_first_ff;
  reg irrx2_ff;
  reg dual_ff;
  reg pwr_sleep_ff;
  reg [2:0] led2_rate_ff;
  reg [2:0] led1_rate_ff;
  reg polarity_ff;
  reg [`LBI_IRQ_BITS-1:0] irq_stat_ff;
  reg [`LBI_IRQ_BITS-1:0] irq_mask_ff;
  reg chassis_prev_ff;
  reg main_prev_ff;
  reg [TICK_W-1:0] tick_cnt_ff;
  reg [8:0] phase_ff;

  wire req = wb_cyc_i & wb_stb_i;
  // Taken once per request; ack low again forces a one-cycle gap
  wire nxt_ack = req & ~wb_ack_o;
  wire [5:0] idx = wb_adr_i[7:2];
  // Write lands on the edge where the master sees ack
  // Only byte lane 0 carries a register; other lanes are ignored
  wire wr = req & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];
  wire wr_b = wr & (idx == `LBI_IDX_PIN_SEL);
  wire wr_c = wr & (idx == `LBI_IDX_BLINK);
  wire wr_d = wr & (idx == `LBI_IDX_POLARITY);
  wire wr_st = wr & (idx == `LBI_IDX_IRQ_STAT);
  wire wr_mk = wr & (idx == `LBI_IDX_IRQ_MASK);

  wire intr_event = chassis_intrusion_input & ~chassis_prev_ff;
  wire main_drop = main_prev_ff & ~main_pwr_good;
  // Main supply loss while standby runs
  wire hw1_load = main_drop & (mode_ff == `LBI_MODE_HW1);
  wire strap_hw1 = (supply_control_straps == STRAP_SUPPLY_OFF);

  // Bit 7 is reserved and reads zero
  wire [7:0] reg_b = {
    1'b0,
    therm_sel_ff,
    chassis_intrusion_input,
    intr_stat_ff,
    mode_ff,
    infrared_receive_first_ff,
    irrx2_ff
  };
  wire [7:0] reg_c = {
    dual_ff,
    pwr_sleep_ff,
    led2_rate_ff,
    led1_rate_ff
  };

  reg [7:0] nxt_rdata;
  always @* begin
    case (idx)
      // Live chassis level
      `LBI_IDX_PIN_SEL: nxt_rdata = reg_b;
      `LBI_IDX_BLINK: nxt_rdata = reg_c;
      // Unused polarity bits read zero
      `LBI_IDX_POLARITY: nxt_rdata = {polarity_ff, 7'h00};
      // Status and mask share one layout
      `LBI_IDX_IRQ_STAT: nxt_rdata = {{(8-`LBI_IRQ_BITS){1'b0}}, irq_stat_ff};
      `LBI_IDX_IRQ_MASK: nxt_rdata = {{(8-`LBI_IRQ_BITS){1'b0}}, irq_mask_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // One wait state: ack one cycle after the request, dropped the next
  always @(posedge core_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= nxt_ack;
      if (nxt_ack) begin
        wb_dat_o <= {24'h000000, nxt_rdata};
      end
    end
  end

  // Edge history tracks the pins even in reset, so a pin already high
  // at release gives no false event
  always @(posedge core_clk) begin
    chassis_prev_ff <= chassis_intrusion_input;
  end

  always @(posedge core_clk) begin
    main_prev_ff <= main_pwr_good;
  end

  // only the standby reset touches the settings
  always @(posedge core_clk) begin
    if (sys_rst) begin
      therm_sel_ff <= 1'b0;
    end else if (wr_b) begin
      therm_sel_ff <= wd[`LBI_B_THERM_SEL];
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      infrared_receive_first_ff <= 1'b0;
    end else if (wr_b) begin
      infrared_receive_first_ff <= wd[`LBI_B_INFRARED_RECEIVE_FIRST_SEL];
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      irrx2_ff <= 1'b0;
    end else if (wr_b) begin
      irrx2_ff <= wd[`LBI_B_IRRX2_SEL];
    end
  end

  // Straps are read on every reset edge, so the last one before release wins
  always @(posedge core_clk) begin
    if (sys_rst) begin
      mode_ff <= strap_hw1 ? `LBI_MODE_HW1 : `LBI_MODE_SW;
    end else if (wr_b) begin
      // mode field, reserved code stored as written
      mode_ff <= wd[`LBI_B_MODE_HI:`LBI_B_MODE_LO];
    end
  end

  // A new intrusion edge beats a clearing write in the same cycle
  always @(posedge core_clk) begin
    if (sys_rst) begin
      intr_stat_ff <= 1'b1;
    end else if (intr_event) begin
      intr_stat_ff <= 1'b1;
    end else if (wr_b & ~wd[`LBI_B_INTR_STAT]) begin
      intr_stat_ff <= 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      dual_ff <= `LBI_RST_DUAL;
      pwr_sleep_ff <= 1'b0;
      led1_rate_ff <= `LBI_RST_LED1;
    end else if (wr_c) begin
      dual_ff <= wd[`LBI_C_DUAL];
      pwr_sleep_ff <= wd[`LBI_C_PWR_SLEEP];
      led1_rate_ff <= wd[`LBI_C_LED1_HI:`LBI_C_LED1_LO];
    end
  end

  // A software write in the same cycle as a supply drop wins; the reload
  // is a convenience default, not a lock
  always @(posedge core_clk) begin
    if (sys_rst) begin
      // LED2 on; 1 Hz at standby power-up in hardware 1
      led2_rate_ff <= strap_hw1 ? `LBI_RATE_1HZ : `LBI_RST_LED2;
    end else if (wr_c) begin
      led2_rate_ff <= wd[`LBI_C_LED2_HI:`LBI_C_LED2_LO];
    end else if (hw1_load) begin
      led2_rate_ff <= `LBI_RATE_1HZ;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      polarity_ff <= 1'b0;
    end else if (wr_d) begin
      polarity_ff <= wd[`LBI_D_POLARITY];
    end
  end

  // Interrupt status, write one to clear, event wins
  wire [`LBI_IRQ_BITS-1:0] irq_set = {hw1_load, intr_event};
  wire [`LBI_IRQ_BITS-1:0] irq_clr = {`LBI_IRQ_BITS{wr_st}} & wd[`LBI_IRQ_BITS-1:0];

  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_stat_ff <= {`LBI_IRQ_BITS{1'b0}};
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_mask_ff <= {`LBI_IRQ_BITS{1'b0}};
    end else if (wr_mk) begin
      irq_mask_ff <= wd[`LBI_IRQ_BITS-1:0];
    end
  end

  // Level output, follows the registers with no extra delay
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // common time base, 384 ticks of 1/48 s per 8 s
  // Tick divider kept apart from the phase so the period can be shortened
  wire tick_done = (tick_cnt_ff == TICK_CYCLES - 1);

  always @(posedge core_clk) begin
    if (sys_rst | tick_done) begin
      tick_cnt_ff <= {TICK_W{1'b0}};
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      phase_ff <= 9'd0;
    end else if (tick_done) begin
      phase_ff <= (phase_ff == `LBI_PERIOD_TICKS - 9'd1) ? 9'd0 : phase_ff + 9'd1;
    end
  end

  // waveform per rate code; periods divide 384 exactly
  function blink;
    input [2:0] code;
    input [8:0] ph;
    begin
      case (code)
        // Always low
        3'h0: blink = 1'b0;
        // 0.25 Hz, high one eighth
        3'h1: blink = (ph % 9'd192) < 9'd24;
        // 0.5 Hz, high one quarter
        3'h2: blink = (ph % 9'd96) < 9'd24;
        // 1 Hz to 4 Hz, half duty
        3'h3: blink = (ph % 9'd48) < 9'd24;
        3'h4: blink = (ph % 9'd24) < 9'd12;
        3'h5: blink = (ph % 9'd16) < 9'd8;
        3'h6: blink = (ph % 9'd12) < 9'd6;
        // Always high
        default: blink = 1'b1;
      endcase
    end
  endfunction

  wire [1:0] lit;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_led
      assign lit[g] = blink(g ? led2_rate_ff : led1_rate_ff, phase_ff);
    end
  endgenerate

  // power LED dark in deep sleep, hardware 2 only
  // Sleep control is ignored in every other mode, reserved code included
  wire pwr_kill = (mode_ff == `LBI_MODE_HW2) & ~pwr_sleep_ff & deep_sleep;
  wire led1_on = lit[0] & ~pwr_kill;
  // one dual-colour LED shows one colour at a time
  wire led2_on = lit[1] & (dual_ff | ~led1_on);

  // polarity applied at the output flops
  // Flopped so the pins never glitch while the phase counter rolls
  always @(posedge core_clk) begin
    if (sys_rst) begin
      led1_out <= 1'b0;
    end else begin
      led1_out <= led1_on ^ polarity_ff;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      led2_out <= 1'b0;
    end else begin
      led2_out <= led2_on ^ polarity_ff;
    end
  end

  // Pin routing selects go straight out
  assign therm_sel = therm_sel_ff;
  assign infrared_receive_first_sel = infrared_receive_first_ff;
  assign irrx2_sel = irrx2_ff;

endmodule

// *** tb/lbi_config_checker.sv ***
`timescale 1ns/1ps
module lbi_config_checker (
  input wire core_clk, // Clock
  input wire sys_rst, // Reset
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write
  input wire [7:0] wb_adr_i, // Address
  input wire [3:0] wb_sel_i, // Byte selects
  input wire [31:0] wb_dat_i, // Write data
  input wire [31:0] wb_dat_o, // Read data
  input wire wb_ack_o, // Acknowledge
  input wire chassis_intrusion_input, // Intrusion pin
  input wire therm_sel, // Sensor pin select
  input wire irq // Interrupt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_idle_no_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
  chk_sel_reset: assert property (disable iff (1'b0) sys_rst |=> !therm_sel && !irq)
    else $error("outputs not reset");
  chk_therm_write: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'hAC && wb_sel_i[0]
    |=> therm_sel == $past(wb_dat_i[6])) else $error("sensor select wrong");
  chk_level_live: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'hAC
    && $stable(chassis_intrusion_input) |-> wb_dat_o[5] == chassis_intrusion_input) else $error("level wrong");
  chk_reserved_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'hAC |-> !wb_dat_o[7])
    else $error("reserved bit set");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> wb_dat_o == 32'h0)
    else $error("unmapped read");
  cov_write: cover property (wb_ack_o && wb_we_i);
  cov_irq: cover property (irq);
  cov_intrusion: cover property ($rose(chassis_intrusion_input));
endmodule
bind lbi_config lbi_config_checker u_lbi_config_checker (.core_clk(core_clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .chassis_intrusion_input(chassis_intrusion_input), .therm_sel(therm_sel), .irq(irq));

// *** tb/test_lbi_config.sv ***
`timescale 1ns/1ps
module test_lbi_config;
  logic core_clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, chas = 0, pg = 1, slp = 0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0, q;
  logic [1:0] strap = 2'h0;
  logic [3:0] sel = 4'h1, lane = 4'h1;
  logic therm_sel, infrared_receive_first_sel, irrx2_sel, led1_out, led2_out, irq, ack;
  logic [31:0] rdat;
  int n_mismatch = 0, n_tests = 0;
  lbi_config #(.TICK_CYCLES(4)) u_lbi_config (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .chassis_intrusion_input(chas), .supply_control_straps(strap), .main_pwr_good(pg),
    .deep_sleep(slp), .therm_sel(therm_sel), .infrared_receive_first_sel(infrared_receive_first_sel), .irrx2_sel(irrx2_sel),
    .led1_out(led1_out), .led2_out(led2_out), .irq(irq));
  initial forever #4 core_clk = ~core_clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {24'h0, d};
    sel <= lane;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) chk(32'h0, 32'h1);
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(0, a, 8'h0);
    chk(q, {24'h0, e});
  endtask
  task lit(input logic [31:0] e);
    int c;
    c = 0;
    repeat (3) @(posedge core_clk);
    repeat (1536) begin
      @(posedge core_clk);
      if (led1_out === 1'b1) c++;
    end
    chk(c, e);
  endtask
  task lit2(input logic [31:0] e);
    int c;
    c = 0;
    repeat (3) @(posedge core_clk);
    repeat (1536) begin
      @(posedge core_clk);
      if (led2_out === 1'b1) c++;
    end
    chk(c, e);
  endtask
  task reset_all(input logic [1:0] s);
    strap <= s; sys_rst <= 1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 0;
  endtask
  task close_out;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task t_reset;
    rd(8'hAC, 8'h10);
    rd(8'hB0, 8'h38);
    rd(8'h00, 8'h00);
    $display("reset values done");
  endtask
  task t_pins;
    bus(1, 8'hAC, 8'h43);
    #1 chk({therm_sel, infrared_receive_first_sel, irrx2_sel}, 3'h7);
    rd(8'hAC, 8'h43);
    bus(1, 8'hAC, 8'h53);
    rd(8'hAC, 8'h43);
    lane = 4'h0;
    bus(1, 8'hAC, 8'h00);
    lane = 4'h1;
    rd(8'hAC, 8'h43);
    $display("pin select done");
  endtask
  task t_intr;
    bus(1, 8'hC4, 8'h03);
    chas <= 1;
    repeat (4) @(posedge core_clk);
    rd(8'hAC, 8'h73);
    rd(8'hC0, 8'h01);
    #1 chk(irq, 1'b1);
    bus(1, 8'hC0, 8'h01);
    @(posedge core_clk);
    #1 chk(irq, 1'b0);
    $display("intrusion done");
  endtask
  task t_blink;
    logic [31:0] e [8] = '{0, 192, 384, 768, 768, 768, 768, 1536};
    for (int i = 0; i < 8; i++) begin
      bus(1, 8'hB0, i[7:0]);
      lit(e[i]);
    end
    bus(1, 8'hB0, 8'h38);
    lit2(1536);
    bus(1, 8'hB0, 8'h3F);
    lit2(0);
    bus(1, 8'hB0, 8'hBF);
    lit2(1536);
    bus(1, 8'hB4, 8'h80);
    bus(1, 8'hB0, 8'h00);
    lit(1536);
    bus(1, 8'hB4, 8'h00);
    $display("blink done");
  endtask
  task t_sleep;
    bus(1, 8'hAC, 8'h4B);
    bus(1, 8'hB0, 8'h07);
    slp <= 1;
    lit(0);
    bus(1, 8'hB0, 8'h47);
    lit(1536);
    slp <= 0;
    $display("sleep done");
  endtask
  task t_reload;
    bus(1, 8'hAC, 8'h47);
    bus(1, 8'hB0, 8'h00);
    pg <= 0;
    repeat (4) @(posedge core_clk);
    rd(8'hB0, 8'h18);
    rd(8'hC0, 8'h02);
    #1 chk(irq, 1'b1);
    pg <= 1;
    reset_all(2'h3);
    rd(8'hAC, 8'h34);
    rd(8'hB0, 8'h18);
    rd(8'hC0, 8'h00);
    $display("reload and strap done");
  endtask
  initial begin
    reset_all(2'h0);
    t_reset;
    t_pins;
    t_intr;
    t_blink;
    t_sleep;
    t_reload;
    close_out;
  end
  initial begin
    #400000;
    n_mismatch++;
    close_out;
  end
endmodule
